// ===== cub_minmax.sv
// max/min selection and unbalance, window comparisons per evaluation step
// assumes phase values and sample strobe come from logic on sys_clk
`timescale 1ns/1ps
module cub_minmax (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic sample_valid,
    input wire logic [cub_pkg::CUR_W-1:0] phase_a_fundamental_rms,
    input wire logic [cub_pkg::CUR_W-1:0] phase_b_fundamental_rms,
    input wire logic [cub_pkg::CUR_W-1:0] phase_c_fundamental_rms,
    input wire logic [cub_pkg::PCT_W-1:0] start_thr,
    input wire logic [cub_pkg::CUR_W-1:0] rated_current,
    output logic flags_valid,
    output logic unbalance,
    output logic max_current_sufficient,
    output logic max_current_not_fault
);
    typedef struct packed {
        logic valid;
        logic unb;
        logic suf;
        logic nf;
    } cub_mm_s;

    cub_mm_s s;
    cub_mm_s next_s;
    logic [cub_pkg::CUR_W-1:0] mx;
    logic [cub_pkg::CUR_W-1:0] mn;
    logic [cub_pkg::PROD_W-1:0] spread_pct;
    logic [cub_pkg::PROD_W-1:0] thr_lim;
    logic [cub_pkg::PROD_W-1:0] mx_pct;

    // largest and smallest phase, then scaled comparisons
    always_comb begin
        next_s = s;
        next_s.valid = sample_valid;
        mx = (phase_a_fundamental_rms > phase_b_fundamental_rms) ?
            phase_a_fundamental_rms : phase_b_fundamental_rms; // see [R01]
        mx = (phase_c_fundamental_rms > mx) ? phase_c_fundamental_rms : mx;
        mn = (phase_a_fundamental_rms < phase_b_fundamental_rms) ?
            phase_a_fundamental_rms : phase_b_fundamental_rms; // see [R01]
        mn = (phase_c_fundamental_rms < mn) ? phase_c_fundamental_rms : mn;
        spread_pct = cub_pkg::PROD_W'(mx - mn) * cub_pkg::PCT_FULL;
        thr_lim = cub_pkg::PROD_W'(start_thr) * cub_pkg::PROD_W'(mx);
        mx_pct = cub_pkg::PROD_W'(mx) * cub_pkg::PCT_FULL;
        if (sample_valid) begin
            next_s.unb = spread_pct > thr_lim; // see [R02]
            next_s.suf = mx_pct > cub_pkg::PROD_W'(rated_current) * cub_pkg::WIN_LO_PCT; // see [R03]
            next_s.nf = mx_pct < cub_pkg::PROD_W'(rated_current) * cub_pkg::WIN_HI_PCT; // see [R03]
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign flags_valid = s.valid;
    assign unbalance = s.unb;
    assign max_current_sufficient = s.suf;
    assign max_current_not_fault = s.nf;

    // equal phases can never show unbalance
    AST_EQUAL_NO_UNB: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [R02]
        (clk_en && sample_valid && phase_a_fundamental_rms == phase_b_fundamental_rms &&
        phase_b_fundamental_rms == phase_c_fundamental_rms) |=> !unbalance)
        else $error("unbalance flagged for equal phases");
endmodule

// ===== cub_pkg.sv
// constants, field positions and types of the current unbalance detector
// assumes a 125 MHz system clock and 16-bit unsigned phase current values
package cub_pkg;
    // clock rate and millisecond tick
    localparam int CLK_FREQ_KHZ = 125000;
    localparam int TICK_TIME_MS = 1;
    localparam int CYCLES_PER_TICK = CLK_FREQ_KHZ * TICK_TIME_MS;
    localparam int PRESC_W = 17;

    // widths
    localparam int CUR_W = 16;
    localparam int PCT_W = 7;
    localparam int DLY_W = 16;
    localparam int PROD_W = 24;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int EV_W = 4;

    // percentages used in the comparisons
    localparam logic [PROD_W-1:0] PCT_FULL = 24'h000064;
    localparam logic [PROD_W-1:0] WIN_LO_PCT = 24'h00000A;
    localparam logic [PROD_W-1:0] WIN_HI_PCT = 24'h000096;

    // setting ranges and reset values
    localparam logic [PCT_W-1:0] THR_MIN = 7'h0A;
    localparam logic [PCT_W-1:0] THR_MAX = 7'h5A;
    localparam logic [PCT_W-1:0] THR_RST = 7'h32;
    localparam logic [DLY_W-1:0] DLY_MIN = 16'h0064;
    localparam logic [DLY_W-1:0] DLY_MAX = 16'hEA60;
    localparam logic [DLY_W-1:0] DLY_RST = 16'h03E8;
    localparam logic [CUR_W-1:0] RATED_RST = 16'h1000;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_THR = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_DELAY = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_RATED = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_EVENT = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_EVMASK = 8'h18;

    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SO_BIT = 1;
    localparam int STS_START_BIT = 0;
    localparam int STS_TRIP_BIT = 1;
    localparam int STS_UNB_BIT = 2;
    localparam int STS_SUF_BIT = 3;
    localparam int STS_NF_BIT = 4;
    localparam int EV_ST_ON = 0;
    localparam int EV_ST_OFF = 1;
    localparam int EV_TR_ON = 2;
    localparam int EV_TR_OFF = 3;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // protection state
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_START = 3'h2,
        ST_TRIP = 3'h4
    } cub_state_e;
endpackage

// ===== cub_src.sv
// upstream stage model: fundamental rms values with a strobe every 4 cycles
// assumes the bench sets the target phase values on sys_clk
`timescale 1ns/1ps
module cub_src (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [15:0] set_a,
    input wire logic [15:0] set_b,
    input wire logic [15:0] set_c,
    output logic sample_valid,
    output logic [15:0] pa,
    output logic [15:0] pb,
    output logic [15:0] pc
);
    logic [1:0] cnt;
    // strobe phase counter
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 2'h0;
        end else begin
            cnt <= cnt + 2'h1;
        end
    end
    // values valid with the strobe only, inverted between strobes
    assign sample_valid = reset_n && cnt == 2'h3;
    assign pa = sample_valid ? set_a : ~set_a;
    assign pb = sample_valid ? set_b : ~set_b;
    assign pc = sample_valid ? set_c : ~set_c;
endmodule

// ===== cub_top.sv
// current unbalance protection: start and delayed trip with AXI4-Lite settings
// Notes on behaviour
// [R01] find largest and smallest phase each step
// [R02] flag unbalance when spread percent exceeds threshold
// [R03] start only with max inside 10-150 % rated
// [R04] start when unbalance and both window conditions
// [R05] operation off blocks start and trip
// [R06] external block input disables the function
// [R07] trip after delay while fault persists, if enabled
// [R08] start-only mode keeps start, never trips
// [R09] threshold 10 to 90 percent, reset 50
// [R10] delay 100 to 60000 ms, reset 1000
// [R11] upstream stage supplies the fundamental RMS values
// [R12] start and trip outputs with on/off events
// [R13] conditions gone: clear timer, drop start, trip
// assumes upstream values, strobe and block input are on sys_clk
`timescale 1ns/1ps
module cub_top #(
    parameter int CYCLES_PER_MS = cub_pkg::CYCLES_PER_TICK
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic sample_valid,
    input wire logic [cub_pkg::CUR_W-1:0] phase_a_fundamental_rms,
    input wire logic [cub_pkg::CUR_W-1:0] phase_b_fundamental_rms,
    input wire logic [cub_pkg::CUR_W-1:0] phase_c_fundamental_rms,
    input wire logic user_block_input,
    output logic general_start_out,
    output logic general_trip_out,
    output logic irq,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [cub_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [cub_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [cub_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [cub_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);
    typedef struct packed {
        logic aw_h;
        logic [cub_pkg::ADDR_W-1:0] aw_addr;
        logic w_h;
        logic [cub_pkg::DATA_W-1:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [cub_pkg::DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic enable;
        logic start_only;
        logic [cub_pkg::PCT_W-1:0] start_thr;
        logic [cub_pkg::DLY_W-1:0] delay_ms;
        logic [cub_pkg::CUR_W-1:0] rated;
        logic [cub_pkg::EV_W-1:0] ev;
        logic [cub_pkg::EV_W-1:0] ev_mask;
        logic irq;
        cub_pkg::cub_state_e state;
        logic [cub_pkg::PRESC_W-1:0] presc;
        logic [cub_pkg::DLY_W-1:0] elapsed;
    } cub_top_s;

    localparam logic [cub_pkg::PRESC_W-1:0] PRESC_LAST = cub_pkg::PRESC_W'(CYCLES_PER_MS - 1);

    cub_top_s s;
    cub_top_s next_s;
    logic flags_valid;
    logic unbalance;
    logic max_current_sufficient;
    logic max_current_not_fault;
    logic active;
    logic cond;
    logic aw_hs;
    logic w_hs;
    logic wr_go;
    logic [cub_pkg::ADDR_W-1:0] wa;
    logic [cub_pkg::DATA_W-1:0] wd;
    logic [3:0] ws;
    logic [cub_pkg::DATA_W-1:0] wm;
    logic [cub_pkg::DATA_W-1:0] rd;
    logic [cub_pkg::ADDR_W-1:0] ra;
    logic rd_ok;
    logic [cub_pkg::EV_W-1:0] ev_clr;
    logic [cub_pkg::EV_W-1:0] ev_set;
    logic timeout;

    // byte-lane merge of a write into an old register value
    function automatic logic [31:0] cub_merge(input logic [31:0] old, input logic [31:0] d,
        input logic [3:0] st);
        logic [31:0] m;
        m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
        return (old & ~m) | (d & m);
    endfunction

    // max/min selection and comparisons of the fundamental values
    cub_minmax u_minmax (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .sample_valid(sample_valid), // see [R11]
        .phase_a_fundamental_rms(phase_a_fundamental_rms),
        .phase_b_fundamental_rms(phase_b_fundamental_rms),
        .phase_c_fundamental_rms(phase_c_fundamental_rms),
        .start_thr(s.start_thr),
        .rated_current(s.rated),
        .flags_valid(flags_valid),
        .unbalance(unbalance),
        .max_current_sufficient(max_current_sufficient),
        .max_current_not_fault(max_current_not_fault)
    );

    // bus handshakes, stalled while a response waits or the clock is frozen
    assign s_axi_awready = clk_en && !s.aw_h && !s.bvalid;
    assign s_axi_wready = clk_en && !s.w_h && !s.bvalid;
    assign s_axi_arready = clk_en && !s.rvalid;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign wr_go = (s.aw_h || aw_hs) && (s.w_h || w_hs) && !s.bvalid;
    assign wa = s.aw_h ? s.aw_addr : s_axi_awaddr;
    assign wd = s.w_h ? s.w_data : s_axi_wdata;
    assign ws = s.w_h ? s.w_strb : s_axi_wstrb;
    assign ra = {s_axi_araddr[cub_pkg::ADDR_W-1:2], 2'h0};

    // function active unless switched off or blocked
    assign active = s.enable && !user_block_input; // see [R05] see [R06]
    assign cond = active && (s.state == cub_pkg::ST_IDLE ?
        (flags_valid && unbalance && max_current_sufficient && max_current_not_fault) :
        (!flags_valid || (unbalance && max_current_sufficient && max_current_not_fault)));
    assign timeout = s.elapsed >= s.delay_ms; // see [R10]

    // read data decode
    always_comb begin
        rd = '0;
        rd_ok = 1'h1;
        if (ra == cub_pkg::OFF_CTRL) begin
            rd[cub_pkg::CTRL_EN_BIT] = s.enable;
            rd[cub_pkg::CTRL_SO_BIT] = s.start_only;
        end else if (ra == cub_pkg::OFF_THR) begin
            rd[cub_pkg::PCT_W-1:0] = s.start_thr;
        end else if (ra == cub_pkg::OFF_DELAY) begin
            rd[cub_pkg::DLY_W-1:0] = s.delay_ms;
        end else if (ra == cub_pkg::OFF_RATED) begin
            rd[cub_pkg::CUR_W-1:0] = s.rated;
        end else if (ra == cub_pkg::OFF_STATUS) begin
            rd[cub_pkg::STS_START_BIT] = general_start_out;
            rd[cub_pkg::STS_TRIP_BIT] = general_trip_out;
            rd[cub_pkg::STS_UNB_BIT] = unbalance;
            rd[cub_pkg::STS_SUF_BIT] = max_current_sufficient;
            rd[cub_pkg::STS_NF_BIT] = max_current_not_fault;
        end else if (ra == cub_pkg::OFF_EVENT) begin
            rd[cub_pkg::EV_W-1:0] = s.ev;
        end else if (ra == cub_pkg::OFF_EVMASK) begin
            rd[cub_pkg::EV_W-1:0] = s.ev_mask;
        end else begin
            rd_ok = 1'h0;
        end
    end

    // next state: bus slave, settings, protection sequence and events
    always_comb begin
        next_s = s;
        wm = '0;
        ev_clr = '0;
        // write channel capture and response
        if (aw_hs && !wr_go) begin
            next_s.aw_h = 1'h1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (w_hs && !wr_go) begin
            next_s.w_h = 1'h1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'h0;
        end
        if (wr_go) begin
            next_s.aw_h = 1'h0;
            next_s.w_h = 1'h0;
            next_s.bvalid = 1'h1;
            next_s.bresp = cub_pkg::RESP_OKAY;
            if (wa[cub_pkg::ADDR_W-1:2] == cub_pkg::OFF_CTRL[cub_pkg::ADDR_W-1:2]) begin
                wm = cub_merge({30'h0, s.start_only, s.enable}, wd, ws);
                next_s.enable = wm[cub_pkg::CTRL_EN_BIT];
                next_s.start_only = wm[cub_pkg::CTRL_SO_BIT];
            end else if (wa[cub_pkg::ADDR_W-1:2] == cub_pkg::OFF_THR[cub_pkg::ADDR_W-1:2]) begin
                wm = cub_merge({25'h0, s.start_thr}, wd, ws);
                // clamp to the settable range
                if (wm < 32'(cub_pkg::THR_MIN)) begin
                    next_s.start_thr = cub_pkg::THR_MIN; // see [R09]
                end else if (wm > 32'(cub_pkg::THR_MAX)) begin
                    next_s.start_thr = cub_pkg::THR_MAX; // see [R09]
                end else begin
                    next_s.start_thr = wm[cub_pkg::PCT_W-1:0];
                end
            end else if (wa[cub_pkg::ADDR_W-1:2] == cub_pkg::OFF_DELAY[cub_pkg::ADDR_W-1:2]) begin
                wm = cub_merge({16'h0, s.delay_ms}, wd, ws);
                if (wm < 32'(cub_pkg::DLY_MIN)) begin
                    next_s.delay_ms = cub_pkg::DLY_MIN; // see [R10]
                end else if (wm > 32'(cub_pkg::DLY_MAX)) begin
                    next_s.delay_ms = cub_pkg::DLY_MAX; // see [R10]
                end else begin
                    next_s.delay_ms = wm[cub_pkg::DLY_W-1:0];
                end
            end else if (wa[cub_pkg::ADDR_W-1:2] == cub_pkg::OFF_RATED[cub_pkg::ADDR_W-1:2]) begin
                wm = cub_merge({16'h0, s.rated}, wd, ws);
                next_s.rated = wm[cub_pkg::CUR_W-1:0];
            end else if (wa[cub_pkg::ADDR_W-1:2] == cub_pkg::OFF_STATUS[cub_pkg::ADDR_W-1:2]) begin
                wm = '0;
            end else if (wa[cub_pkg::ADDR_W-1:2] == cub_pkg::OFF_EVENT[cub_pkg::ADDR_W-1:2]) begin
                wm = cub_merge('0, wd, ws);
                ev_clr = wm[cub_pkg::EV_W-1:0];
            end else if (wa[cub_pkg::ADDR_W-1:2] == cub_pkg::OFF_EVMASK[cub_pkg::ADDR_W-1:2]) begin
                wm = cub_merge({28'h0, s.ev_mask}, wd, ws);
                next_s.ev_mask = wm[cub_pkg::EV_W-1:0];
            end else begin
                next_s.bresp = cub_pkg::RESP_SLVERR;
            end
        end
        // read channel
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'h0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_s.rvalid = 1'h1;
            next_s.rdata = rd;
            next_s.rresp = rd_ok ? cub_pkg::RESP_OKAY : cub_pkg::RESP_SLVERR;
        end
        // millisecond timer runs from the appearance of the fault state
        if (s.state == cub_pkg::ST_IDLE || !cond) begin
            next_s.presc = '0; // see [R13]
            next_s.elapsed = '0; // see [R13]
        end else if (s.presc == PRESC_LAST) begin
            next_s.presc = '0;
            if (s.elapsed != cub_pkg::DLY_MAX) begin
                next_s.elapsed = s.elapsed + 16'h0001; // see [R07]
            end
        end else begin
            next_s.presc = s.presc + 17'h00001;
        end
        // protection sequence
        case (s.state)
            cub_pkg::ST_IDLE: begin
                if (cond) begin
                    next_s.state = cub_pkg::ST_START; // see [R04]
                end
            end
            cub_pkg::ST_START: begin
                if (!cond) begin
                    next_s.state = cub_pkg::ST_IDLE; // see [R13]
                end else if (timeout && !s.start_only) begin
                    next_s.state = cub_pkg::ST_TRIP; // see [R07] see [R08]
                end
            end
            cub_pkg::ST_TRIP: begin
                if (!cond) begin
                    next_s.state = cub_pkg::ST_IDLE; // see [R13]
                end else if (s.start_only) begin
                    next_s.state = cub_pkg::ST_START; // see [R08]
                end
            end
            default: begin
                next_s.state = cub_pkg::ST_IDLE;
            end
        endcase
        // on/off events of start and trip, a set wins over a clear
        ev_set = '0;
        ev_set[cub_pkg::EV_ST_ON] = s.state == cub_pkg::ST_IDLE &&
            next_s.state != cub_pkg::ST_IDLE; // see [R12]
        ev_set[cub_pkg::EV_ST_OFF] = s.state != cub_pkg::ST_IDLE &&
            next_s.state == cub_pkg::ST_IDLE; // see [R12]
        ev_set[cub_pkg::EV_TR_ON] = s.state != cub_pkg::ST_TRIP &&
            next_s.state == cub_pkg::ST_TRIP; // see [R12]
        ev_set[cub_pkg::EV_TR_OFF] = s.state == cub_pkg::ST_TRIP &&
            next_s.state != cub_pkg::ST_TRIP; // see [R12]
        next_s.ev = (s.ev & ~ev_clr) | ev_set;
        next_s.irq = |(next_s.ev & next_s.ev_mask);
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
            s.start_thr <= cub_pkg::THR_RST; // see [R09]
            s.delay_ms <= cub_pkg::DLY_RST; // see [R10]
            s.rated <= cub_pkg::RATED_RST;
            s.state <= cub_pkg::ST_IDLE;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign general_start_out = s.state != cub_pkg::ST_IDLE; // see [R12]
    assign general_trip_out = s.state == cub_pkg::ST_TRIP; // see [R12]
    assign irq = s.irq;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;

    // checks on the protection behaviour
    AST_OFF_NO_START: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [R05]
        (clk_en && !s.enable) |=> !general_start_out && !general_trip_out)
        else $error("start or trip while operation off");
    AST_BLOCK_NO_OUT: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [R06]
        (clk_en && user_block_input) |=> !general_start_out && !general_trip_out)
        else $error("start or trip while blocked");
    AST_START_ONLY: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [R08]
        (clk_en && s.start_only) |=> !general_trip_out)
        else $error("trip in start-only mode");
    AST_TRIP_WITH_START: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [R13]
        general_trip_out |-> general_start_out && $past(general_start_out))
        else $error("trip without start");
    AST_TRIP_AFTER_DELAY: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [R07]
        $rose(general_trip_out) |-> $past(s.elapsed) >= $past(s.delay_ms))
        else $error("trip before delay elapsed");
    AST_START_ON_COND: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [R04]
        (clk_en && active && flags_valid && unbalance && max_current_sufficient &&
        max_current_not_fault) |=> general_start_out)
        else $error("start missing on fault");
    AST_WINDOW_LOW: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [R03]
        (clk_en && flags_valid && (!max_current_sufficient || !max_current_not_fault))
        |=> !general_start_out)
        else $error("start outside current window");
    AST_THR_RANGE: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [R09]
        s.start_thr >= cub_pkg::THR_MIN && s.start_thr <= cub_pkg::THR_MAX)
        else $error("threshold out of range");
    AST_START_EVENT: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [R12]
        $rose(general_start_out) |-> s.ev[cub_pkg::EV_ST_ON])
        else $error("start on event not recorded");
    AST_TIMER_CLEAR: assert property (@(posedge sys_clk) disable iff (!reset_n) // see [R13]
        $fell(general_start_out) |-> s.elapsed == '0 && s.presc == '0)
        else $error("timer not cleared with start");

    COV_START: cover property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(general_start_out));
    COV_TRIP: cover property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(general_trip_out));
    COV_START_ONLY: cover property (@(posedge sys_clk) disable iff (!reset_n)
        general_start_out && s.start_only && s.elapsed >= s.delay_ms);
    COV_IRQ: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(irq));
endmodule

// ===== tb.sv
// bench of the unbalance detector: register access and protection cases
// assumes the upstream model strobes every 4 cycles and 4 cycles per ms
`timescale 1ns/1ps
module tb;
    logic sys_clk = 0, reset_n = 0, blk = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, sv, start, trip, irq, awready, wready, bvalid, arready, rvalid;
    logic [15:0] sa = 0, sb = 0, sc = 0, pa, pb, pc;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [1:0] bresp, rresp, r;
    int miscompares = 0, tests_run = 0, cyc = 0;
    // free running clock
    always #4 sys_clk = ~sys_clk;
    cub_src src (.sys_clk(sys_clk), .reset_n(reset_n), .set_a(sa), .set_b(sb), .set_c(sc),
        .sample_valid(sv), .pa(pa), .pb(pb), .pc(pc));
    cub_top #(.CYCLES_PER_MS(4)) uut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1),
        .sample_valid(sv), .phase_a_fundamental_rms(pa), .phase_b_fundamental_rms(pb),
        .phase_c_fundamental_rms(pc), .user_block_input(blk), .general_start_out(start),
        .general_trip_out(trip), .irq(irq), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // ends on a falling edge so that outputs are looked at while settled
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw_ok, w_ok, b_ok;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // decide on settled values, act right after the next rising edge
        do begin
            @(negedge sys_clk);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bvalid;
            r = bresp;
            @(posedge sys_clk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end while (!b_ok);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        logic ar_ok, r_ok;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge sys_clk);
            ar_ok = arvalid && arready;
            r_ok = rvalid;
            d = rdata;
            r = rresp;
            @(posedge sys_clk);
            if (ar_ok) arvalid <= 1'b0;
        end while (!r_ok);
        rready <= 1'b0;
    endtask
    task automatic ph(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        @(posedge sys_clk);
        sa <= a;
        sb <= b;
        sc <= c;
        wait_cyc(12);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // cycle ceiling against a hang
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            wrap_up();
        end
    end
    // test sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(8'h00);
        chk(d, 32'h0);
        rd(8'h04);
        chk(d, 32'h32);
        rd(8'h08);
        chk(d, 32'h3E8);
        rd(8'h40);
        chk(r, cub_pkg::RESP_SLVERR);
        wr(8'h40, 32'h1);
        chk(r, cub_pkg::RESP_SLVERR);
        wr(8'h18, 32'hF);
        chk(r, cub_pkg::RESP_OKAY);
        ph(16'h03E8, 16'h03E8, 16'h0190);
        chk(start, 1'b0);
        $display("test reset and off done");
        wr(8'h00, 32'h1);
        wait_cyc(12);
        chk(start, 1'b1);
        chk(irq, 1'b1);
        rd(8'h14);
        chk(d, 32'h1);
        ph(16'h012C, 16'h012C, 16'h0064);
        chk(start, 1'b0);
        ph(16'h1B58, 16'h1B58, 16'h03E8);
        chk(start, 1'b0);
        ph(16'h03E8, 16'h01F4, 16'h03E8);
        chk(start, 1'b0);
        ph(16'h03E8, 16'h03E8, 16'h01F3);
        chk(start, 1'b1);
        wr(8'h04, 32'h5);
        rd(8'h04);
        chk(d, 32'h0A);
        wr(8'h04, 32'h5F);
        rd(8'h04);
        chk(d, 32'h5A);
        wr(8'h04, 32'h32);
        wr(8'h08, 32'h32);
        rd(8'h08);
        chk(d, 32'h64);
        $display("test window and settings done");
        ph(16'h03E8, 16'h03E8, 16'h03E8);
        chk(start, 1'b0);
        wr(8'h14, 32'hF);
        wait_cyc(2);
        chk(irq, 1'b0);
        // start rises 2 to 5 cycles after the new values, trip 401 cycles later
        ph(16'h03E8, 16'h03E8, 16'h0190);
        wait_cyc(388);
        chk(trip, 1'b0);
        wait_cyc(8);
        chk(trip, 1'b1);
        ph(16'h03E8, 16'h03E8, 16'h03E8);
        chk({start, trip}, 2'h0);
        rd(8'h14);
        chk(d, 32'hF);
        $display("test delayed trip done");
        wr(8'h00, 32'h3);
        ph(16'h03E8, 16'h03E8, 16'h0190);
        wait_cyc(500);
        chk({start, trip}, 2'h2);
        rd(8'h10);
        chk(d, 32'h1D);
        blk <= 1'b1;
        wait_cyc(4);
        chk(start, 1'b0);
        $display("test start only and block done");
        wrap_up();
    end
endmodule
